//--- rtl/cpu_core_regs_and_icache.sv
// Register files, PC, status, field unit and LRU instruction cache
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module cpu_core_regs_and_icache
  import core_store_pkg::*;
#(
  parameter int SEGS = SEG_NUM
)(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic rf_we,
  input wire logic rf_wfile,
  input wire logic [3:0] rf_waddr,
  input wire logic [31:0] rf_wdata,
  input wire logic rf_rfile,
  input wire logic [3:0] rf_raddr,
  output logic [31:0] rf_rdata,
  input wire logic pixel_op_active,
  input wire logic pix_we,
  input wire logic [3:0] pix_waddr,
  input wire logic [31:0] pix_wdata,
  input wire logic [3:0] pix_raddr,
  output logic [31:0] pix_rdata,
  output logic [31:0] stack_ptr,
  input wire logic pc_load,
  input wire logic [31:0] pc_load_val,
  input wire logic pc_advance,
  output logic [31:0] pc,
  input wire logic pstat_we,
  input wire logic [31:0] pstat_wdata,
  input wire logic cc_we,
  input wire logic [3:0] cc_in,
  output logic [31:0] processor_status,
  input wire logic irq_take,
  input wire logic op_interruptible,
  output logic [31:0] stacked_status,
  input wire logic instr_retire,
  output logic trap_req,
  output logic [31:0] trap_vector,
  input wire logic fx_req,
  input wire logic fx_sel,
  input wire logic [1:0] fx_kind,
  input wire logic fx_byte_signed,
  input wire logic [4:0] fx_bitoff,
  input wire logic [63:0] fx_data,
  input wire logic [5:0] pix_size,
  output logic fx_valid,
  output logic [31:0] fx_result,
  output logic pix_align_ok,
  input wire logic if_req,
  input wire logic [31:0] if_addr,
  output fetch_rsp_s if_rsp,
  output logic mc_req,
  output logic [31:0] mc_addr,
  input wire logic mc_rvalid,
  input wire logic [31:0] mc_rdata,
  output lad_drive_s local_addr_data_bus,
  output logic address_latch_strobe,
  input wire logic narrow_bus_select_n,
  output logic narrow_word_odd
);

  if (SEGS != 4)
  begin : g_seg_check
    $error("Cache logic serves exactly four segments");
  end

  // Move a segment to the top of the usage stack
  function automatic logic [7:0] lru_touch(input logic [7:0] stk, input logic [1:0] s);
    logic [7:0] r;
    logic found;
    r = stk;
    found = 1'b0;
    for (int i = 3; i > 0; i--)
    begin
      if (stk[2*i +: 2] == s)
        found = 1'b1;
      if (found)
        r[2*i +: 2] = stk[2*(i-1) +: 2];
    end
    r[1:0] = s;
    return r;
  endfunction : lru_touch

  // Shared aligner for fields, bytes, words and long words
  function automatic logic [31:0] extract(input logic [63:0] d, input logic [4:0] off,
                                          input logic [5:0] w, input logic sx);
    logic [63:0] sh;
    logic [31:0] m;
    logic [31:0] r;
    sh = d >> off;
    m = (w >= 6'd32) ? 32'hffff_ffff : ((32'h1 << w[4:0]) - 32'h1);
    r = sh[31:0] & m;
    if (sx && w < 6'd32 && w != 6'd0 && r[w[4:0] - 5'd1])
      r = r | ~m;
    return r;
  endfunction : extract

  // Pixel sizes 1..32 in powers of two, never straddling a long word
  function automatic logic pix_fits(input logic [4:0] off, input logic [5:0] sz);
    logic ok;
    ok = (sz == 6'd1) || (sz == 6'd2) || (sz == 6'd4) || (sz == 6'd8) || (sz == 6'd16)
      || (sz == 6'd32);
    return ok && ((off & (sz[4:0] - 5'd1)) == 5'd0);
  endfunction : pix_fits

  logic [31:0] file_a_q [15];
  logic [31:0] file_b_q [15];
  logic [31:0] sp_q;
  logic [31:0] pc_q;
  logic [31:0] pstat_q;
  logic [31:0] stk_pstat_q;
  logic trap_q;
  logic [31:0] rf_rd_q;
  logic [31:0] pix_rd_q;
  logic gen_we_b;

  // File B writes from software are held off while the pixel engine owns it
  assign gen_we_b = rf_we && rf_wfile && !pixel_op_active;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 15; i++)
      begin
        file_a_q[i] <= 32'h0000_0000;
        file_b_q[i] <= 32'h0000_0000;
      end
      sp_q <= 32'h0000_0000;
    end
    else
    begin
      if (rf_we && !rf_wfile && rf_waddr != 4'(SP_IDX))
        file_a_q[rf_waddr] <= rf_wdata;
      if (pixel_op_active && pix_we && pix_waddr != 4'(SP_IDX))
        file_b_q[pix_waddr] <= pix_wdata;
      else if (gen_we_b && rf_waddr != 4'(SP_IDX))
        file_b_q[rf_waddr] <= rf_wdata;
      if ((rf_we && (!rf_wfile || !pixel_op_active)) && rf_waddr == 4'(SP_IDX))
        sp_q <= rf_wdata;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rf_rd_q <= 32'h0000_0000;
      pix_rd_q <= 32'h0000_0000;
    end
    else
    begin
      if (rf_raddr == 4'(SP_IDX))
        rf_rd_q <= sp_q;
      else if (rf_rfile)
        rf_rd_q <= file_b_q[rf_raddr];
      else
        rf_rd_q <= file_a_q[rf_raddr];
      pix_rd_q <= (pix_raddr == 4'(SP_IDX)) ? sp_q : file_b_q[pix_raddr];
    end
  end

  assign rf_rdata = rf_rd_q;
  assign pix_rdata = pix_rd_q;
  assign stack_ptr = sp_q;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      pc_q <= 32'h0000_0000;
    else if (pc_load)
      pc_q <= {pc_load_val[31:4], 4'h0};
    else if (pc_advance)
      pc_q <= pc_q + PC_STEP;
  end

  assign pc = {pc_q[31:4], 4'h0};

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      pstat_q <= PS_RESET;
    else if (pstat_we)
      pstat_q <= pstat_wdata;
    else if (cc_we)
      pstat_q[PS_CC_LSB +: 4] <= cc_in;
  end

  assign processor_status = pstat_q;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      stk_pstat_q <= 32'h0000_0000;
    else if (irq_take)
    begin
      stk_pstat_q <= pstat_q;
      stk_pstat_q[PS_INTR] <= op_interruptible;
    end
  end

  assign stacked_status = stk_pstat_q;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      trap_q <= 1'b0;
    else
      trap_q <= instr_retire && pstat_q[PS_SSTEP];
  end

  assign trap_req = trap_q;
  assign trap_vector = SSTEP_VECTOR;

  logic fx_v_q;
  logic [31:0] fx_q;
  logic pix_ok_q;
  logic [5:0] fx_w;
  logic [4:0] fx_off;
  logic fx_sx;
  logic [4:0] fs_sel;

  always_comb
  begin
    fs_sel = fx_sel ? pstat_q[PS_W1_LSB +: 5] : pstat_q[PS_W0_LSB +: 5];
    fx_w = (fs_sel == 5'd0) ? 6'd32 : {1'b0, fs_sel};
    fx_sx = fx_sel ? pstat_q[PS_X1] : pstat_q[PS_X0];
    fx_off = fx_bitoff;
    case (fx_kind)
      KIND_BYTE:
      begin
        fx_w = 6'd8;
        fx_sx = fx_byte_signed;
      end
      KIND_WORD:
      begin
        fx_w = 6'd16;
        fx_sx = 1'b0;
        fx_off = 5'd0;
      end
      KIND_LONG:
      begin
        fx_w = 6'd32;
        fx_sx = 1'b0;
        fx_off = 5'd0;
      end
      default:
      begin
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      fx_v_q <= 1'b0;
      fx_q <= 32'h0000_0000;
      pix_ok_q <= 1'b0;
    end
    else
    begin
      fx_v_q <= fx_req;
      if (fx_req)
      begin
        fx_q <= extract(fx_data, fx_off, fx_w, fx_sx);
        pix_ok_q <= pix_fits(fx_bitoff, pix_size);
      end
    end
  end

  assign fx_valid = fx_v_q;
  assign fx_result = fx_q;
  assign pix_align_ok = pix_ok_q;

  logic [TAG_W-1:0] tag_q [4];
  logic [7:0] pres_q [4];
  logic seg_used_q [4];
  logic [31:0] line_q [128];
  logic [7:0] lru_q;
  fill_state_e fst_q;
  logic [1:0] fseg_q;
  logic [2:0] fsub_q;
  logic [1:0] beat_q;
  logic [31:0] faddr_q;
  logic [TAG_W-1:0] req_tag;
  logic [2:0] req_sub;
  logic [3:0] tag_match;
  logic hit;
  logic tag_hit;
  logic [1:0] hit_seg;
  logic [1:0] victim;
  fetch_rsp_s rsp_q;
  logic nb_s1_q;
  logic nb_s2_q;

  assign req_tag = if_addr[31:TAG_LSB];
  assign req_sub = if_addr[SUB_LSB +: 3];
  assign victim = lru_q[7:6];

  always_comb
  begin
    hit = 1'b0;
    tag_hit = 1'b0;
    hit_seg = 2'd0;
    for (int s = 0; s < 4; s++)
    begin
      tag_match[s] = seg_used_q[s] && (tag_q[s] == req_tag);
      if (tag_match[s])
      begin
        tag_hit = 1'b1;
        hit_seg = 2'(s);
        hit = pres_q[s][req_sub];
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      fst_q <= S_IDLE;
      fseg_q <= 2'd0;
      fsub_q <= 3'd0;
      beat_q <= 2'd0;
      faddr_q <= 32'h0000_0000;
      lru_q <= 8'he4;
      for (int s = 0; s < 4; s++)
      begin
        tag_q[s] <= '0;
        pres_q[s] <= 8'h00;
        seg_used_q[s] <= 1'b0;
      end
    end
    else
    begin
      case (fst_q)
        S_IDLE:
        begin
          if (if_req && hit)
            lru_q <= lru_touch(lru_q, hit_seg);
          else if (if_req)
          begin
            fst_q <= S_ADDR;
            fsub_q <= req_sub;
            beat_q <= 2'd0;
            faddr_q <= {if_addr[31:SUB_LSB], 7'h00};
            if (tag_hit)
              fseg_q <= hit_seg;
            else
            begin
              fseg_q <= victim;
              tag_q[victim] <= req_tag;
              pres_q[victim] <= 8'h00;
              seg_used_q[victim] <= 1'b1;
            end
          end
        end
        S_ADDR:
          fst_q <= S_DATA;
        S_DATA:
        begin
          if (mc_rvalid)
          begin
            beat_q <= beat_q + 2'd1;
            if (beat_q == 2'(LW_PER_SUB - 1))
            begin
              pres_q[fseg_q][fsub_q] <= 1'b1;
              lru_q <= lru_touch(lru_q, fseg_q);
              fst_q <= S_DONE;
            end
          end
        end
        S_DONE:
          fst_q <= S_IDLE;
        default:
          fst_q <= S_IDLE;
      endcase
    end
  end

  // Fill data lands in the addressed subsegment one long word per beat
  always_ff @(posedge clk_sys)
  begin
    if (fst_q == S_DATA && mc_rvalid)
      line_q[{fseg_q, fsub_q, beat_q}] <= mc_rdata;
  end

  logic [31:0] hit_lw;
  assign hit_lw = line_q[{hit_seg, req_sub, if_addr[LW_LSB +: 2]}];

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      rsp_q <= '0;
    else
    begin
      rsp_q.valid <= (fst_q == S_IDLE) && if_req && hit;
      rsp_q.data <= if_addr[WSEL_BIT] ? hit_lw[31:16] : hit_lw[15:0];
    end
  end

  assign if_rsp = rsp_q;
  assign mc_req = (fst_q == S_ADDR) || (fst_q == S_DATA);
  assign mc_addr = faddr_q;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      nb_s1_q <= 1'b1;
      nb_s2_q <= 1'b1;
    end
    else
    begin
      nb_s1_q <= narrow_bus_select_n;
      nb_s2_q <= nb_s1_q;
    end
  end

  // Address phase: strobe high in S_ADDR, falls while address still driven
  assign address_latch_strobe = (fst_q == S_ADDR);
  assign local_addr_data_bus.oe = (fst_q == S_ADDR) || (fst_q == S_DATA);
  assign local_addr_data_bus.data = {faddr_q[31:4], BUS_STAT_FETCH};
  assign narrow_word_odd = !nb_s2_q && faddr_q[WSEL_BIT];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_pc_low_zero: assert property (pc_q[3:0] == 4'h0)
    else $error("PC low bits not zero");
  a_sp_shared: assert property (rf_we && rf_waddr == 4'hf && !rf_wfile
      ##1 rf_raddr == 4'hf && rf_rfile |=> rf_rdata == $past(rf_wdata, 2))
    else $error("SP not shared between files");
  a_hit_quiet: assert property (fst_q == S_IDLE && if_req && hit
      |=> if_rsp.valid && !mc_req && !address_latch_strobe)
    else $error("Hit caused memory traffic");
  a_miss_fills: assert property (fst_q == S_IDLE && if_req && !hit
      |=> address_latch_strobe ##1 !address_latch_strobe && local_addr_data_bus.oe)
    else $error("Miss did not start address phase");
  a_victim_lru: assert property (fst_q == S_IDLE && if_req && !tag_hit
      |=> tag_q[$past(lru_q[7:6])] == $past(if_addr[31:10]))
    else $error("Victim not least recently used");
  a_sub_present: assert property (fst_q == S_DATA && mc_rvalid && beat_q == 2'd3
      |=> pres_q[fseg_q][fsub_q] && fst_q == S_DONE ##1 fst_q == S_IDLE)
    else $error("Subsegment not marked present");
  a_step_trap: assert property (instr_retire |=> trap_req == $past(pstat_q[PS_SSTEP]))
    else $error("Single-step trap wrong");
  a_intr_stacked: assert property (irq_take && op_interruptible
      |=> stacked_status[PS_INTR] && stacked_status[25:0] == $past(pstat_q[25:0]))
    else $error("Interrupted flag not stacked");
  a_byte_width: assert property (fx_req && fx_kind == KIND_BYTE && !fx_byte_signed
      |=> fx_valid && fx_result[31:8] == 24'h0)
    else $error("Byte extract wider than 8");
  a_word_addr: assert property ($fell(address_latch_strobe)
      |-> local_addr_data_bus.data[31:4] == $past(mc_addr[31:4]))
    else $error("Word address not valid at strobe fall");

  c_hit: cover property (if_req && hit ##1 if_rsp.valid);
  c_fill_then_hit: cover property (fst_q == S_DONE ##1 if_req && hit);
  c_evict: cover property (fst_q == S_IDLE && if_req && !tag_hit && seg_used_q[victim]);
  c_trap: cover property (trap_req);

endmodule : cpu_core_regs_and_icache
`default_nettype wire

//--- rtl/core_store_pkg.sv
// Shared constants and carriers for the core storage and fetch block
package core_store_pkg;
  localparam int SEG_NUM = 4;
  localparam int SUB_NUM = 8;
  localparam int LW_PER_SUB = 4;
  localparam int TAG_W = 22;
  localparam int TAG_LSB = 10;
  localparam int SUB_LSB = 7;
  localparam int LW_LSB = 5;
  localparam int WSEL_BIT = 4;
  localparam int SP_IDX = 15;
  // Status register layout
  localparam int PS_W0_LSB = 0;
  localparam int PS_X0 = 5;
  localparam int PS_W1_LSB = 6;
  localparam int PS_X1 = 11;
  localparam int PS_SSTEP = 25;
  localparam int PS_INTR = 26;
  localparam int PS_CC_LSB = 28;
  localparam logic [31:0] PS_RESET = 32'h0000_0000;
  localparam logic [31:0] SSTEP_VECTOR = 32'hffff_fbe0;
  localparam logic [3:0] BUS_STAT_FETCH = 4'h1;
  localparam logic [31:0] PC_STEP = 32'h0000_0010;
  // Data kinds for the field unit
  localparam logic [1:0] KIND_FIELD = 2'h0;
  localparam logic [1:0] KIND_BYTE = 2'h1;
  localparam logic [1:0] KIND_WORD = 2'h2;
  localparam logic [1:0] KIND_LONG = 2'h3;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_ADDR = 4'b0010,
    S_DATA = 4'b0100,
    S_DONE = 4'b1000
  } fill_state_e;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } fetch_rsp_s;

  typedef struct packed {
    logic [31:0] data;
    logic oe;
  } lad_drive_s;
endpackage : core_store_pkg

//--- sim/mem_model.sv
// Behavioural local memory that answers subsegment fills
`timescale 1ns/100ps
`default_nettype none
module mem_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic mc_req,
  input wire logic [31:0] mc_addr,
  input wire logic [3:0] slow,
  output logic mc_rvalid,
  output logic [31:0] mc_rdata
);
  logic req_q;
  logic busy_q;
  logic [31:0] base_q;
  logic [1:0] beat_q;
  logic [3:0] wait_q;
  logic [15:0] lw;
  assign lw = base_q[20:5] + 16'(beat_q);
  always_ff @(posedge clk_sys)
  begin
    req_q <= mc_req;
    mc_rvalid <= 1'b0;
    // Idle data keeps toggling so a stale beat is never taken for a fresh one
    mc_rdata <= ~mc_rdata;
    if (sys_rst)
    begin
      busy_q <= 1'b0;
      mc_rdata <= 32'h0;
    end
    else if (mc_req && !req_q && !busy_q)
    begin
      busy_q <= 1'b1;
      base_q <= mc_addr;
      beat_q <= 2'h0;
      wait_q <= slow;
    end
    else if (busy_q && wait_q != 4'h0)
      wait_q <= wait_q - 4'h1;
    else if (busy_q)
    begin
      // Four long words in order make one subsegment
      mc_rvalid <= 1'b1;
      mc_rdata <= {~lw, lw};
      beat_q <= beat_q + 2'h1;
      wait_q <= slow;
      if (beat_q == 2'h3)
        busy_q <= 1'b0;
    end
  end
endmodule : mem_model
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the core storage and fetch block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb
  import core_store_pkg::*;
;
  typedef struct packed {logic wf; logic [3:0] wa; logic [31:0] wd;
    logic rf; logic [3:0] ra; logic [31:0] ex;} rf_row_s;
  typedef struct packed {logic [31:0] a; logic miss;} ic_row_s;
  typedef struct packed {logic [31:0] ps; logic [1:0] k; logic s; logic bs;
    logic [4:0] o; logic [5:0] w; logic sx;} fx_row_s;
  localparam logic [5:0] P_LOAD = 6'h01;
  localparam logic [5:0] P_ADV = 6'h02;
  localparam logic [5:0] P_STAT = 6'h04;
  localparam logic [5:0] P_CC = 6'h08;
  localparam logic [5:0] P_IRQ = 6'h10;
  localparam logic [5:0] P_RET = 6'h20;
  logic clk_sys, sys_rst, rf_we, rf_wfile, rf_rfile, pixel_op_active, pix_we;
  logic pc_load, pc_advance, pstat_we, cc_we, irq_take, op_interruptible, instr_retire;
  logic fx_req, fx_sel, fx_byte_signed, if_req, mc_req, mc_rvalid, address_latch_strobe;
  logic narrow_bus_select_n, narrow_word_odd, trap_req, fx_valid, pix_align_ok;
  logic [3:0] rf_waddr, rf_raddr, pix_waddr, pix_raddr, cc_in, slow;
  logic [31:0] rf_wdata, rf_rdata, pix_wdata, pix_rdata, stack_ptr, pc_load_val, pc;
  logic [31:0] pstat_wdata, processor_status, stacked_status, trap_vector, fx_result;
  logic [31:0] if_addr, mc_addr, mc_rdata, fill_base;
  logic [1:0] fx_kind;
  logic [4:0] fx_bitoff;
  logic [63:0] fx_data;
  logic [5:0] pix_size, pls;
  logic [15:0] w;
  fetch_rsp_s if_rsp;
  lad_drive_s local_addr_data_bus;
  int fails = 0;
  int cmp_count = 0;
  int fills = 0;
  int f0;
  rf_row_s rows [6] = '{
    '{1'b0, 4'h0, 32'h1111_0000, 1'b0, 4'h0, 32'h1111_0000},
    '{1'b1, 4'he, 32'h2222_000e, 1'b1, 4'he, 32'h2222_000e},
    '{1'b0, 4'he, 32'h3333_000e, 1'b1, 4'he, 32'h2222_000e},
    '{1'b0, 4'hf, 32'h0000_1000, 1'b1, 4'hf, 32'h0000_1000},
    '{1'b1, 4'hf, 32'h0000_2000, 1'b0, 4'hf, 32'h0000_2000},
    '{1'b1, 4'h7, 32'hffff_ffff, 1'b1, 4'h7, 32'hffff_ffff}};
  ic_row_s ic [12] = '{'{32'h0000_0450, 1'b1}, '{32'h0000_0460, 1'b0},
    '{32'h0000_0690, 1'b1}, '{32'h0000_0800, 1'b1}, '{32'h8000_0c30, 1'b1},
    '{32'h0000_1000, 1'b1}, '{32'h0000_0450, 1'b0}, '{32'h0000_1400, 1'b1},
    '{32'h0000_0690, 1'b0}, '{32'h8000_0c30, 1'b0}, '{32'h0000_1000, 1'b0},
    '{32'h0000_0800, 1'b1}};
  fx_row_s fxr [8] = '{
    '{32'h0000_0025, KIND_FIELD, 1'b0, 1'b0, 5'd31, 6'd5, 1'b1},
    '{32'h0000_0025, KIND_FIELD, 1'b1, 1'b0, 5'd24, 6'd32, 1'b0},
    '{32'h0000_0b00, KIND_FIELD, 1'b1, 1'b0, 5'd24, 6'd12, 1'b1},
    '{32'h0000_0b00, KIND_FIELD, 1'b0, 1'b0, 5'd7, 6'd32, 1'b0},
    '{32'h0000_0b00, KIND_BYTE, 1'b0, 1'b1, 5'd29, 6'd8, 1'b1},
    '{32'h0000_0b00, KIND_BYTE, 1'b0, 1'b0, 5'd13, 6'd8, 1'b0},
    '{32'h0000_0b00, KIND_WORD, 1'b0, 1'b0, 5'd12, 6'd16, 1'b0},
    '{32'h0000_0b00, KIND_LONG, 1'b0, 1'b0, 5'd9, 6'd32, 1'b0}};
  assign {instr_retire, irq_take, cc_we, pstat_we, pc_advance, pc_load} = pls;
  cpu_core_regs_and_icache cpu_core_regs_and_icache_i (.*);
  mem_model mem_model_i (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    if (address_latch_strobe === 1'b1)
    begin
      fills++;
      `CHK("fill addr", {fill_base[31:7], 7'h0}, mc_addr)
      `CHK("bus addr", {mc_addr[31:4], BUS_STAT_FETCH}, local_addr_data_bus.data)
      `CHK("bus oe", 1'b1, local_addr_data_bus.oe)
      `CHK("odd word", 1'b0, narrow_word_odd)
    end
  function automatic logic [15:0] exp_w(input logic [31:0] a);
    return a[4] ? ~a[20:5] : a[20:5];
  endfunction : exp_w
  function automatic logic [31:0] fld(input logic [63:0] d, input int o, input int n,
    input logic sx);
    logic [63:0] m;
    m = (64'h1 << n) - 64'h1;
    d = (d >> o) & m;
    if (sx && d[n-1])
      d = d | ~m;
    return d[31:0];
  endfunction : fld
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic pulse(input logic [5:0] m);
    @(posedge clk_sys);
    pls <= m;
    @(posedge clk_sys);
    pls <= 6'h0;
    #1;
  endtask : pulse
  task automatic rf_wr(input logic f, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    rf_we <= 1'b1;
    rf_wfile <= f;
    rf_waddr <= a;
    rf_wdata <= d;
    @(posedge clk_sys);
    rf_we <= 1'b0;
  endtask : rf_wr
  task automatic pix_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    pix_we <= 1'b1;
    pix_waddr <= a;
    pix_wdata <= d;
    @(posedge clk_sys);
    pix_we <= 1'b0;
  endtask : pix_wr
  task automatic rd(input logic f, input logic [3:0] a);
    @(posedge clk_sys);
    rf_rfile <= f;
    rf_raddr <= a;
    pix_raddr <= a;
    @(posedge clk_sys);
    #1;
  endtask : rd
  task automatic fetch(input logic [31:0] a);
    int n;
    @(posedge clk_sys);
    if_req <= 1'b1;
    if_addr <= a;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (if_rsp.valid !== 1'b1 && n < 200);
    w = if_rsp.data;
    if_req <= 1'b0;
    if (n >= 200)
      fails++;
  endtask : fetch
  task automatic fx(input fx_row_s r);
    @(posedge clk_sys);
    fx_req <= 1'b1;
    {fx_sel, fx_kind, fx_byte_signed, fx_bitoff} <= {r.s, r.k, r.bs, r.o};
    @(posedge clk_sys);
    fx_req <= 1'b0;
    #1;
  endtask : fx
  initial
  begin
    #200000;
    fails++;
    end_sim();
  end
  initial
  begin
    {rf_we, rf_wfile, rf_rfile, pixel_op_active, pix_we, fx_req, fx_sel} = '0;
    {fx_byte_signed, if_req, op_interruptible, rf_waddr, rf_raddr, pix_waddr} = '0;
    {pix_raddr, cc_in, slow, rf_wdata, pix_wdata, pc_load_val, pstat_wdata} = '0;
    {if_addr, fill_base, fx_kind, fx_bitoff, pix_size, pls} = '0;
    fx_data = 64'h9234_5678_9abc_5ef0;
    narrow_bus_select_n = 1'b1;
    sys_rst = 1'b1;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    `CHK("reset regs", 32'h0, pc | processor_status | stack_ptr)
    `CHK("vector", SSTEP_VECTOR, trap_vector)
    foreach (rows[i])
    begin
      rf_wr(rows[i].wf, rows[i].wa, rows[i].wd);
      rd(rows[i].rf, rows[i].ra);
      `CHK("reg read", rows[i].ex, rf_rdata)
    end
    rd(1'b1, 4'hf);
    rf_wr(1'b0, 4'hf, 32'h5555_0000);
    rd(1'b1, 4'hf);
    `CHK("sp back to back", 32'h5555_0000, rf_rdata)
    rf_wr(1'b1, 4'hf, 32'h0000_2000);
    rd(1'b0, 4'hf);
    `CHK("stack ptr", 32'h0000_2000, stack_ptr)
    @(posedge clk_sys);
    pixel_op_active <= 1'b1;
    rf_wr(1'b1, 4'h7, 32'h0);
    rf_wr(1'b1, 4'hf, 32'h0);
    pix_wr(4'h7, 32'h7777_0007);
    pix_wr(4'hf, 32'h0);
    rf_wr(1'b0, 4'h7, 32'haaaa_0007);
    rd(1'b1, 4'h7);
    `CHK("pix b7", 32'h7777_0007, rf_rdata)
    `CHK("pix rd", 32'h7777_0007, pix_rdata)
    rd(1'b0, 4'h7);
    `CHK("file a7", 32'haaaa_0007, rf_rdata)
    `CHK("sp kept", 32'h0000_2000, stack_ptr)
    @(posedge clk_sys);
    pixel_op_active <= 1'b0;
    pix_wr(4'h7, 32'h0);
    rd(1'b1, 4'h7);
    `CHK("pix idle", 32'h7777_0007, pix_rdata)
    pc_load_val <= 32'h1234_567f;
    pulse(P_LOAD);
    `CHK("pc load", 32'h1234_5670, pc)
    pulse(P_ADV);
    `CHK("pc step", 32'h1234_5680, pc)
    pc_load_val <= 32'h0000_00a9;
    pulse(P_LOAD | P_ADV);
    `CHK("pc wins", 32'h0000_00a0, pc)
    pstat_wdata <= 32'hf000_0b00;
    pulse(P_STAT);
    `CHK("status", 32'hf000_0b00, processor_status)
    cc_in <= 4'h5;
    pulse(P_CC);
    `CHK("cond codes", 32'h5000_0b00, processor_status)
    op_interruptible <= 1'b1;
    pulse(P_IRQ);
    `CHK("stacked intr", 32'h5400_0b00, stacked_status)
    pstat_wdata <= 32'h0400_0b00;
    op_interruptible <= 1'b0;
    pulse(P_STAT);
    pulse(P_IRQ);
    `CHK("stacked no intr", 32'h0000_0b00, stacked_status)
    for (int s = 0; s < 2; s++)
    begin
      pstat_wdata <= s ? 32'h0 : 32'h0200_0000;
      pulse(P_STAT);
      pulse(P_RET);
      `CHK("trap", s ? 1'b0 : 1'b1, trap_req)
      @(posedge clk_sys);
      #1;
      `CHK("trap pulse", 1'b0, trap_req)
    end
    pix_size <= 6'd8;
    foreach (fxr[i])
    begin
      pstat_wdata <= fxr[i].ps;
      pulse(P_STAT);
      fx(fxr[i]);
      `CHK("fx valid", 1'b1, fx_valid)
      `CHK("fx result", fld(fx_data, fxr[i].k[1] ? 0 : int'(fxr[i].o), int'(fxr[i].w),
        fxr[i].sx), fx_result)
      if (fxr[i].k == KIND_FIELD)
        `CHK("pix align", fxr[i].o[2:0] == 3'h0, pix_align_ok)
    end
    narrow_bus_select_n <= 1'b0;
    foreach (ic[i])
    begin
      f0 = fills;
      slow <= 4'(i % 3);
      fill_base = ic[i].a;
      fetch(ic[i].a);
      `CHK("fetch word", exp_w(ic[i].a), w)
      `CHK("fill count", 32'(ic[i].miss), 32'(fills - f0))
    end
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    `CHK("rerun regs", 32'h0, pc | processor_status | stack_ptr)
    f0 = fills;
    fill_base = 32'h0000_0460;
    fetch(32'h0000_0460);
    `CHK("refill word", exp_w(32'h0000_0460), w)
    `CHK("refill", 1, fills - f0)
    end_sim();
  end
endmodule : tb
`default_nettype wire
